// [pkg/psrb_pkg.sv]
// Constants of the port status register bank: addresses, field positions,
// reset values and synchroniser layout.
// Assumes the bank design file reaches these through psrb_pkg::name; the link port uses none of them.
package psrb_pkg;

  // Register addresses on the two-bit register address.
  localparam logic [1:0] PSRB_ADDR_EVENT_AND_LEVEL_REPORT = 2'h0;
  localparam logic [1:0] PSRB_ADDR_LINE_DRIVER_SETUP = 2'h1;
  localparam logic [1:0] PSRB_ADDR_AUX_IO_SETUP = 2'h2;
  localparam logic [1:0] PSRB_ADDR_OPERATING_MODE_FLAGS = 2'h3;

  // Report register fields.
  localparam int PSRB_ST_AUX_LEVEL = 5;
  localparam int PSRB_ST_PORT_LEVEL_INV = 4;
  localparam int PSRB_EV_PORT_FAULT = 3;
  localparam int PSRB_EV_LOW_RAIL = 2;
  localparam int PSRB_EV_FIELD_SUPPLY = 1;
  localparam int PSRB_EV_OVERTEMP = 0;

  // Auxiliary setup fields.
  localparam int PSRB_AUX_LEVEL_OUT_OFF = 1;
  localparam int PSRB_AUX_LOAD_EN = 0;

  // Line setup field that gates the receive output.
  localparam int PSRB_LINE_RECEIVER_OFF = 1;

  // Operating mode fields.
  localparam int PSRB_MODE_SOFT_RESET = 7;
  localparam int PSRB_MODE_WAKE_SW_ENABLE = 6;
  localparam int PSRB_MODE_PORT_FAULT_FLAG = 4;
  localparam int PSRB_MODE_FIELD_SUPPLY_FLAG = 3;
  localparam int PSRB_MODE_OVERTEMP_FLAG = 2;
  localparam int PSRB_MODE_LOW_RAIL_MON_EN = 1;
  localparam int PSRB_MODE_LOW_RAIL_REG_OFF = 0;

  // Values after reset.
  localparam logic [7:0] PSRB_LINE_RESET = 8'h00;
  localparam logic [1:0] PSRB_AUX_RESET = 2'h0;
  localparam logic [3:0] PSRB_EV_RESET = 4'h0;
  localparam logic [7:0] PSRB_RDATA_RESET = 8'h00;

  // Condition input positions inside the synchroniser vector.
  localparam int PSRB_IN_AUX = 0;
  localparam int PSRB_IN_PORT_LINE = 1;
  localparam int PSRB_IN_FAULT = 2;
  localparam int PSRB_IN_LOW_RAIL = 3;
  localparam int PSRB_IN_FIELD = 4;
  localparam int PSRB_IN_OT_WARN = 5;
  localparam int PSRB_IN_OT_COOL = 6;
  localparam int PSRB_IN_W = 7;
  localparam logic [6:0] PSRB_IN_RESET = 7'h00;

endpackage : psrb_pkg

// [hdl/psrb_link_port.sv]
// Link-clock side of the register access path.
// Assumes the link clock keeps running while an access is outstanding and
// that the core side answers each request toggle with one acknowledge toggle.
`timescale 1ns/1ns
module psrb_link_port (
  // Clock and reset.
  input wire logic link_clk_i,
  input wire logic resetn_i,
  // Link-side access.
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [1:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o,
  // Core-side crossing.
  output logic req_tgl_o,
  output logic req_write_o,
  output logic [1:0] req_addr_o,
  output logic [7:0] req_wdata_o,
  input wire logic ack_tgl_i,
  input wire logic [7:0] ack_rdata_i
);

  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic done;
    logic [7:0] rdata;
  } psrb_link_type;

  psrb_link_type st_r;
  psrb_link_type st_nxt;

  // Request fields are held stable until the acknowledge returns, so the
  // core can sample them once it sees the synchronised toggle.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack_s1 = ack_tgl_i;
    st_nxt.ack_s2 = st_r.ack_s1;
    st_nxt.done = 1'b0;
    if (!st_r.busy && acc_valid_i) begin
      st_nxt.busy = 1'b1;
      st_nxt.req_tgl = ~st_r.req_tgl;
      st_nxt.wr = acc_write_i;
      st_nxt.addr = acc_addr_i;
      st_nxt.wdata = acc_wdata_i;
    end
    if (st_r.busy && (st_r.ack_s2 != st_r.ack_seen)) begin
      st_nxt.ack_seen = st_r.ack_s2;
      st_nxt.rdata = ack_rdata_i;
      st_nxt.done = 1'b1;
      st_nxt.busy = 1'b0;
    end
  end

  // State register of the link domain.
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs.
  assign acc_ready_o = ~st_r.busy;
  assign acc_done_o = st_r.done;
  assign acc_rdata_o = st_r.rdata;
  assign req_tgl_o = st_r.req_tgl;
  assign req_write_o = st_r.wr;
  assign req_addr_o = st_r.addr;
  assign req_wdata_o = st_r.wdata;

endmodule : psrb_link_port

// [hdl/psrb_bank.sv]
// Port status register bank: four 8-bit registers, event latching and the
// active-low interrupt request of a field-port master transceiver.
// Assumes condition inputs come from analog detectors (asynchronous levels)
// and register accesses arrive on the link clock through psrb_link_port.
// Behaviour
// - Four registers, each eight bits wide.
// - Two-bit address selects report, line, aux, mode.
// - Report holds levels D5-D4 and events D3-D0.
// - Report register ignores all host writes.
// - Report read clears events, keeps level bits.
// - Persisting port fault sets event again immediately.
// - Events and unused bits reset to zero.
// - Aux level bit tracks input, never interrupts.
// - Port level bit inverted, live, never interrupts.
// - Port fault sets event and flag, interrupts.
// - Alarm latches interrupt until report read.
// - Low-rail event interrupts only when monitor enabled.
// - Undervoltage output needs enabled low-rail event and live low-rail input.
// - Field supply fault sets event, flag, interrupt.
// - Overtemp flag sets event and interrupt.
// - Overtemp event rearms only after cooling down.
// - Line and aux setup read-write, reset zero.
// - Contents kept while logic supply present.
`timescale 1ns/1ns
module psrb_bank (
  // Clocks and reset.
  input wire logic core_clk_i,
  input wire logic link_clk_i,
  input wire logic resetn_i,
  // Register access on the link clock.
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [1:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o,
  // Detector and line condition inputs.
  input wire logic aux_field_input_i,
  input wire logic port_line_i,
  input wire logic port_fault_i,
  input wire logic low_rail_under_i,
  input wire logic field_supply_under_i,
  input wire logic overtemp_warn_i,
  input wire logic overtemp_cool_i,
  // Outputs to pins and analog control.
  output logic irq_n_o,
  output logic undervoltage_out_o,
  output logic aux_level_out_o,
  output logic port_rx_o,
  output logic [7:0] line_driver_setup_o,
  output logic aux_load_en_o,
  output logic wake_sw_enable_o,
  output logic low_rail_reg_off_o
);

  typedef struct packed {
    logic [6:0] in_s1;
    logic [6:0] in_s2;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [7:0] line_cfg;
    logic [1:0] aux_cfg;
    logic wake_en;
    logic lr_mon_en;
    logic lr_reg_off;
    logic ot_flag;
    logic [3:0] ev;
  } psrb_core_type;

  psrb_core_type st_r;
  psrb_core_type st_nxt;

  logic req_tgl;
  logic req_write;
  logic [1:0] req_addr;
  logic [7:0] req_wdata;
  logic acc;
  logic rd_report;
  logic aux_lvl;
  logic port_inv;
  logic fault_live;
  logic lr_live;
  logic fs_live;
  logic [7:0] report;
  logic [7:0] mode;
  logic [7:0] rd_mux;
  logic [3:0] ev_set;

  // Link-domain half of the access path.
  psrb_link_port u_link (
    .link_clk_i(link_clk_i),
    .resetn_i(resetn_i),
    .acc_valid_i(acc_valid_i),
    .acc_write_i(acc_write_i),
    .acc_addr_i(acc_addr_i),
    .acc_wdata_i(acc_wdata_i),
    .acc_ready_o(acc_ready_o),
    .acc_done_o(acc_done_o),
    .acc_rdata_o(acc_rdata_o),
    .req_tgl_o(req_tgl),
    .req_write_o(req_write),
    .req_addr_o(req_addr),
    .req_wdata_o(req_wdata),
    .ack_tgl_i(st_r.ack_tgl),
    .ack_rdata_i(st_r.rdata)
  );

  // Synchronised condition levels; only the second stage is read here.
  assign aux_lvl = st_r.in_s2[psrb_pkg::PSRB_IN_AUX];
  assign port_inv = ~st_r.in_s2[psrb_pkg::PSRB_IN_PORT_LINE];
  assign fault_live = st_r.in_s2[psrb_pkg::PSRB_IN_FAULT];
  assign lr_live = st_r.in_s2[psrb_pkg::PSRB_IN_LOW_RAIL];
  assign fs_live = st_r.in_s2[psrb_pkg::PSRB_IN_FIELD];

  // An access is pending when the synchronised toggle differs from the
  // last one served; address and data are stable by then.
  assign acc = st_r.req_s2 != st_r.req_seen;
  assign rd_report = acc && !req_write
    && (req_addr == psrb_pkg::PSRB_ADDR_EVENT_AND_LEVEL_REPORT);

  always_comb begin
    report = 8'h00;
    report[psrb_pkg::PSRB_ST_AUX_LEVEL] = aux_lvl;
    report[psrb_pkg::PSRB_ST_PORT_LEVEL_INV] = port_inv;
    report[3:0] = st_r.ev;
  end

  // Mode register view: flags are hardware state, the rest is written.
  always_comb begin
    mode = 8'h00;
    mode[psrb_pkg::PSRB_MODE_WAKE_SW_ENABLE] = st_r.wake_en;
    mode[psrb_pkg::PSRB_MODE_PORT_FAULT_FLAG] = fault_live;
    mode[psrb_pkg::PSRB_MODE_FIELD_SUPPLY_FLAG] = fs_live;
    mode[psrb_pkg::PSRB_MODE_OVERTEMP_FLAG] = st_r.ot_flag;
    mode[psrb_pkg::PSRB_MODE_LOW_RAIL_MON_EN] = st_r.lr_mon_en;
    mode[psrb_pkg::PSRB_MODE_LOW_RAIL_REG_OFF] = st_r.lr_reg_off;
  end

  always_comb begin
    case (req_addr)
      psrb_pkg::PSRB_ADDR_EVENT_AND_LEVEL_REPORT: rd_mux = report;
      psrb_pkg::PSRB_ADDR_LINE_DRIVER_SETUP: rd_mux = st_r.line_cfg;
      psrb_pkg::PSRB_ADDR_AUX_IO_SETUP: rd_mux = {6'h00, st_r.aux_cfg};
      psrb_pkg::PSRB_ADDR_OPERATING_MODE_FLAGS: rd_mux = mode;
      default: rd_mux = 8'h00;
    endcase
  end

  // Event sources; overtemp fires on the flag's rising edge only.
  always_comb begin
    ev_set = 4'h0;
    ev_set[psrb_pkg::PSRB_EV_PORT_FAULT] = fault_live;
    ev_set[psrb_pkg::PSRB_EV_LOW_RAIL] = lr_live;
    ev_set[psrb_pkg::PSRB_EV_FIELD_SUPPLY] = fs_live;
    // Rearm after cooling
    // Taken from registered state so this block never feeds on st_nxt.
    ev_set[psrb_pkg::PSRB_EV_OVERTEMP] =
      st_r.in_s2[psrb_pkg::PSRB_IN_OT_WARN] && !st_r.ot_flag;
  end

  // Next-state logic of the core domain.
  always_comb begin
    st_nxt = st_r;
    st_nxt.in_s1 = {overtemp_cool_i, overtemp_warn_i, field_supply_under_i,
      low_rail_under_i, port_fault_i, port_line_i, aux_field_input_i};
    st_nxt.in_s2 = st_r.in_s1;
    st_nxt.req_s1 = req_tgl;
    st_nxt.req_s2 = st_r.req_s1;
    if (st_r.in_s2[psrb_pkg::PSRB_IN_OT_WARN]) begin
      st_nxt.ot_flag = 1'b1;
    end else if (st_r.in_s2[psrb_pkg::PSRB_IN_OT_COOL]) begin
      st_nxt.ot_flag = 1'b0;
    end
    if (acc) begin
      st_nxt.req_seen = st_r.req_s2;
      st_nxt.ack_tgl = ~st_r.ack_tgl;
      st_nxt.rdata = rd_mux;
      if (req_write) begin
        case (req_addr)
          psrb_pkg::PSRB_ADDR_LINE_DRIVER_SETUP: begin
            st_nxt.line_cfg = req_wdata;
          end
          psrb_pkg::PSRB_ADDR_AUX_IO_SETUP: begin
            st_nxt.aux_cfg = req_wdata[1:0];
          end
          psrb_pkg::PSRB_ADDR_OPERATING_MODE_FLAGS: begin
            st_nxt.wake_en = req_wdata[psrb_pkg::PSRB_MODE_WAKE_SW_ENABLE];
            st_nxt.lr_mon_en = req_wdata[psrb_pkg::PSRB_MODE_LOW_RAIL_MON_EN];
            st_nxt.lr_reg_off =
              req_wdata[psrb_pkg::PSRB_MODE_LOW_RAIL_REG_OFF];
            // Soft reset returns the setup registers to their idle values.
            if (req_wdata[psrb_pkg::PSRB_MODE_SOFT_RESET]) begin
              st_nxt.line_cfg = psrb_pkg::PSRB_LINE_RESET;
              st_nxt.aux_cfg = psrb_pkg::PSRB_AUX_RESET;
              st_nxt.wake_en = 1'b0;
              st_nxt.lr_mon_en = 1'b0;
              st_nxt.lr_reg_off = 1'b0;
            end
          end
          default: begin
            st_nxt.line_cfg = st_r.line_cfg;
          end
        endcase
      end
    end
    if (rd_report) begin
      st_nxt.ev = psrb_pkg::PSRB_EV_RESET;
    end
    st_nxt.ev = st_nxt.ev | ev_set;
  end

  // The logic reset clears all contents
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r.in_s1 <= psrb_pkg::PSRB_IN_RESET;
      st_r.in_s2 <= psrb_pkg::PSRB_IN_RESET;
      st_r.req_s1 <= 1'b0;
      st_r.req_s2 <= 1'b0;
      st_r.req_seen <= 1'b0;
      st_r.ack_tgl <= 1'b0;
      st_r.rdata <= psrb_pkg::PSRB_RDATA_RESET;
      st_r.line_cfg <= psrb_pkg::PSRB_LINE_RESET;
      st_r.aux_cfg <= psrb_pkg::PSRB_AUX_RESET;
      st_r.wake_en <= 1'b0;
      st_r.lr_mon_en <= 1'b0;
      st_r.lr_reg_off <= 1'b0;
      st_r.ot_flag <= 1'b0;
      st_r.ev <= psrb_pkg::PSRB_EV_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq_n_o = ~(st_r.ev[psrb_pkg::PSRB_EV_PORT_FAULT]
    | st_r.ev[psrb_pkg::PSRB_EV_FIELD_SUPPLY]
    | st_r.ev[psrb_pkg::PSRB_EV_OVERTEMP]
    | (st_r.ev[psrb_pkg::PSRB_EV_LOW_RAIL] & st_r.lr_mon_en));

  assign undervoltage_out_o = st_r.lr_mon_en
    & st_r.ev[psrb_pkg::PSRB_EV_LOW_RAIL] & lr_live;

  assign aux_level_out_o = ~aux_lvl
    & ~st_r.aux_cfg[psrb_pkg::PSRB_AUX_LEVEL_OUT_OFF];
  // Receive output forced high while the receiver is switched off.
  assign port_rx_o = port_inv
    | st_r.line_cfg[psrb_pkg::PSRB_LINE_RECEIVER_OFF];
  assign line_driver_setup_o = st_r.line_cfg;
  assign aux_load_en_o = st_r.aux_cfg[psrb_pkg::PSRB_AUX_LOAD_EN];
  assign wake_sw_enable_o = st_r.wake_en;
  assign low_rail_reg_off_o = st_r.lr_reg_off;

  // Checks of the core domain.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_read_report;
    rd_report;
  endsequence

  sequence s_flag_held;
    st_r.ot_flag [*4];
  endsequence

  a_read_clears: assert property (
    s_read_report ##0 (ev_set == 4'h0) |=> (st_r.ev == 4'h0))
    else $error("report read did not clear events");

  a_fault_resets: assert property (
    s_read_report ##0 fault_live |=> st_r.ev[3])
    else $error("persisting fault not set again after read");

  a_ot_once: assert property (
    s_read_report ##0 st_r.ot_flag ##1 s_flag_held |-> !st_r.ev[0])
    else $error("overtemp event set again without cooling");

  a_report_wr_ro: assert property (
    acc && req_write && (req_addr == 2'h0) && (ev_set == 4'h0)
    |=> $stable(st_r.ev))
    else $error("write to report changed events");

  a_line_write: assert property (
    acc && req_write && (req_addr == 2'h1)
    |=> (st_r.line_cfg == $past(req_wdata)))
    else $error("line setup write not stored");

  a_irq_pending: assert property (
    st_r.ev[3] || st_r.ev[1] || st_r.ev[0] |-> !irq_n_o)
    else $error("interrupt not asserted with event pending");

  a_irq_release: assert property (
    s_read_report ##0 (ev_set == 4'h0) |=> irq_n_o)
    else $error("interrupt not released after clearing read");

  a_low_rail_mask: assert property (
    (st_r.ev == 4'h4) && !st_r.lr_mon_en |-> irq_n_o)
    else $error("masked low-rail event raised interrupt");

  a_uv_out: assert property (
    undervoltage_out_o |-> st_r.lr_mon_en && st_r.ev[2])
    else $error("undervoltage output without enabled event");

  a_level_read: assert property (
    acc && !req_write && (req_addr == 2'h0)
    |=> (st_r.rdata[5] == $past(aux_lvl)) && (st_r.rdata[7:6] == 2'h0)
        && (st_r.rdata[4] == $past(port_inv)))
    else $error("report levels wrong in read data");

  a_rx_live: assert property (
    !st_r.line_cfg[1] |-> (port_rx_o == port_inv))
    else $error("receive output not following port level");

endmodule : psrb_bank

// [sim/psrb_host_model.sv]
// Host model: issues one register access at a time on the link clock.
// Assumes the bank answers every taken access with one done pulse.
`timescale 1ns/1ns
module psrb_host_model (
  // Link clock.
  input wire logic link_clk_i,
  // Access answer.
  input wire logic acc_ready_i,
  input wire logic acc_done_i,
  input wire logic [7:0] acc_rdata_i,
  // Access request.
  output logic acc_valid_o,
  output logic acc_write_o,
  output logic [1:0] acc_addr_o,
  output logic [7:0] acc_wdata_o
);
  // Idle request lines at time zero.
  initial begin
    acc_valid_o = 1'b0;
    acc_write_o = 1'b0;
    acc_addr_o = 2'h0;
    acc_wdata_o = 8'h00;
  end

  // The request is held until an edge sees ready high; afterwards the
  // qualifiers are inverted so a stale address can never pass for live.
  task automatic xfer(input logic wr, input logic [1:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    int n;
    n = 0;
    rdata = 8'hxx;
    @(posedge link_clk_i);
    #1;
    acc_valid_o = 1'b1;
    acc_write_o = wr;
    acc_addr_o = addr;
    acc_wdata_o = wdata;
    do begin
      @(posedge link_clk_i);
      n++;
    end while (acc_ready_i !== 1'b1 && n < 50);
    #1;
    acc_valid_o = 1'b0;
    acc_write_o = ~wr;
    acc_addr_o = ~addr;
    acc_wdata_o = ~wdata;
    n = 0;
    do begin
      @(posedge link_clk_i);
      n++;
    end while (acc_done_i !== 1'b1 && n < 50);
    if (acc_done_i === 1'b1) begin
      rdata = acc_rdata_i;
    end
  endtask : xfer
endmodule : psrb_host_model

// [sim/testbench.sv]
// Self-checking bench for the port status register bank.
// Assumes the host model in psrb_host_model drives the access port.
`timescale 1ns/1ns
module testbench;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic valid, write, ready, done;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, line_setup;
  logic aux_in = 1'b0;
  logic line_in = 1'b1;
  logic fault = 1'b0;
  logic low_rail = 1'b0;
  logic field_uv = 1'b0;
  logic ot_warn = 1'b0;
  logic ot_cool = 1'b0;
  logic irq_n, uv_out, aux_lvl, port_rx, aux_load, wake_en, rail_off;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;

  psrb_bank DUT (
    .core_clk_i(core_clk), .link_clk_i(link_clk), .resetn_i(resetn),
    .acc_valid_i(valid), .acc_write_i(write), .acc_addr_i(addr),
    .acc_wdata_i(wdata), .acc_ready_o(ready), .acc_done_o(done),
    .acc_rdata_o(rdata), .aux_field_input_i(aux_in),
    .port_line_i(line_in), .port_fault_i(fault),
    .low_rail_under_i(low_rail), .field_supply_under_i(field_uv),
    .overtemp_warn_i(ot_warn), .overtemp_cool_i(ot_cool),
    .irq_n_o(irq_n), .undervoltage_out_o(uv_out),
    .aux_level_out_o(aux_lvl), .port_rx_o(port_rx),
    .line_driver_setup_o(line_setup), .aux_load_en_o(aux_load),
    .wake_sw_enable_o(wake_en), .low_rail_reg_off_o(rail_off));

  psrb_host_model host (
    .link_clk_i(link_clk), .acc_ready_i(ready), .acc_done_i(done),
    .acc_rdata_i(rdata), .acc_valid_o(valid), .acc_write_o(write),
    .acc_addr_o(addr), .acc_wdata_o(wdata));

  // Two unrelated clocks: 10 ns core, 12 ns link.
  always #5 core_clk = ~core_clk;
  always #6 link_clk = ~link_clk;

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well above the few hundred cycles the run needs.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] v;
    host.xfer(1'b1, a, d, v);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.xfer(1'b0, a, 8'h00, v);
    chk(v, exp);
  endtask : rd

  // Conditions change together after a core edge, then get past the
  // two-stage synchroniser and the event latch.
  task automatic cond(input logic [6:0] c);
    @(posedge core_clk);
    #1;
    {ot_cool, ot_warn, field_uv, low_rail, fault, line_in, aux_in} = c;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : cond

  task automatic t_reset;
    chk({7'h00, irq_n}, 8'h01);
    chk({7'h00, uv_out}, 8'h00);
    chk(line_setup, 8'h00);
    chk({6'h00, ready, done}, 8'h02);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    rd(2'h0, 8'h00);
  endtask : t_reset

  task automatic t_rw;
    wr(2'h1, 8'ha5);
    rd(2'h1, 8'ha5);
    chk(line_setup, 8'ha5);
    wr(2'h2, 8'hff);
    rd(2'h2, 8'h03);
    chk({6'h00, aux_load, aux_lvl}, 8'h02);
    wr(2'h3, 8'h43);
    rd(2'h3, 8'h43);
    chk({6'h00, wake_en, rail_off}, 8'h03);
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    // Soft reset through mode bit 7 returns the setup registers to zero.
    wr(2'h3, 8'hc3);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    rd(2'h3, 8'h00);
    chk(line_setup, 8'h00);
    chk({6'h00, aux_load, wake_en}, 8'h00);
  endtask : t_rw

  task automatic t_levels;
    cond(7'h01);
    rd(2'h0, 8'h30);
    rd(2'h0, 8'h30);
    chk({5'h00, irq_n, aux_lvl, port_rx}, 8'h05);
    cond(7'h03);
    chk({7'h00, port_rx}, 8'h00);
    wr(2'h1, 8'h02);
    chk({7'h00, port_rx}, 8'h01);
    cond(7'h01);
    rd(2'h0, 8'h30);
    chk({7'h00, irq_n}, 8'h01);
    wr(2'h1, 8'h00);
    cond(7'h02);
  endtask : t_levels

  task automatic t_field;
    cond(7'h12);
    chk({7'h00, irq_n}, 8'h00);
    rd(2'h3, 8'h08);
    cond(7'h02);
    chk({7'h00, irq_n}, 8'h00);
    rd(2'h0, 8'h02);
    chk({7'h00, irq_n}, 8'h01);
    rd(2'h0, 8'h00);
  endtask : t_field

  task automatic t_fault;
    cond(7'h06);
    chk({7'h00, irq_n}, 8'h00);
    rd(2'h3, 8'h10);
    rd(2'h0, 8'h08);
    rd(2'h0, 8'h08);
    chk({7'h00, irq_n}, 8'h00);
    cond(7'h02);
    rd(2'h0, 8'h08);
    rd(2'h0, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
  endtask : t_fault

  task automatic t_rail;
    cond(7'h0a);
    chk({6'h00, irq_n, uv_out}, 8'h02);
    rd(2'h0, 8'h04);
    cond(7'h02);
    wr(2'h3, 8'h02);
    cond(7'h0a);
    chk({6'h00, irq_n, uv_out}, 8'h01);
    cond(7'h02);
    chk({6'h00, irq_n, uv_out}, 8'h00);
    rd(2'h0, 8'h04);
    chk({7'h00, irq_n}, 8'h01);
    wr(2'h3, 8'h00);
  endtask : t_rail

  task automatic t_temp;
    cond(7'h22);
    chk({7'h00, irq_n}, 8'h00);
    rd(2'h3, 8'h04);
    rd(2'h0, 8'h01);
    rd(2'h0, 8'h00);
    chk({7'h00, irq_n}, 8'h01);
    cond(7'h02);
    cond(7'h22);
    rd(2'h0, 8'h00);
    cond(7'h42);
    rd(2'h3, 8'h00);
    cond(7'h22);
    rd(2'h0, 8'h01);
    cond(7'h42);
    cond(7'h02);
  endtask : t_temp

  // Reset for four core cycles, then every scenario in turn.
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_reset();
    t_rw();
    t_levels();
    t_field();
    t_fault();
    t_rail();
    t_temp();
    report_and_stop();
  end
endmodule : testbench
